// file: mbagu_pkg.sv
/*
 Package for the modulo and bit-reversed address adjustment block.
 Holds field positions, reset values, access modes and register indexes.
 Assumes a 16-bit data address space and sixteen pointer registers.
*/
`default_nettype none
package mbagu_pkg;

   // =========================================================
   // Widths
   localparam int AW = 16;
   localparam int PW = 4;

   // =========================================================
   // Control register fields
   localparam int CTL_XSEL_LO  = 0;
   localparam int CTL_YSEL_LO  = 4;
   localparam int CTL_BSEL_LO  = 8;
   localparam int CTL_YEN_BIT  = 14;
   localparam int CTL_XEN_BIT  = 15;
   localparam logic [3:0] PTR_NONE = 4'hf;

   // Modifier register fields
   localparam int BRV_EN_BIT   = 15;
   localparam int BRV_PIV_MSB  = 14;

   // Reset values
   localparam logic [15:0] CTL_RESET = 16'h0fff;
   localparam logic [15:0] BRV_RESET = 16'h0000;

   // =========================================================
   // Software register port indexes
   localparam logic [2:0] REG_CTL    = 3'h0;
   localparam logic [2:0] REG_BRV    = 3'h1;
   localparam logic [2:0] REG_XSTART = 3'h2;
   localparam logic [2:0] REG_XEND   = 3'h3;
   localparam logic [2:0] REG_YSTART = 3'h4;
   localparam logic [2:0] REG_YEND   = 3'h5;
   localparam logic [2:0] REG_LAST   = 3'h6;

   // =========================================================
   // Addressing forms of an access
   typedef enum logic [2:0] {
      MBA_IND,
      MBA_POSTINC,
      MBA_POSTDEC,
      MBA_PREINC,
      MBA_PREDEC,
      MBA_OFFSET
   } mba_mode_t;

   // Address spaces
   typedef enum logic {
      MBA_SPACE_X,
      MBA_SPACE_Y
   } mba_space_t;

endpackage
`default_nettype wire

// file: mba_if.sv
/*
 Interface joining the processor core to the address adjustment block.
 Assumes one shared clock; the core holds a request for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
interface mba_if
   import mbagu_pkg::*;
   (
   input wire logic mclk,
   input wire logic rst_n
   );

   // Access request from the core
   logic            req;
   logic            wr;
   logic            byte_acc;
   mba_space_t      space;
   mba_mode_t       mode;
   logic [PW-1:0]   ptr_sel;
   logic [AW-1:0]   ptr_val;
   logic [AW-1:0]   step;
   // Register port from the core
   logic            reg_wr;
   logic            reg_rd;
   logic [2:0]      reg_addr;
   logic [15:0]     reg_wdata;
   // Answers from the block
   logic            ack;
   logic [AW-1:0]   ea;
   logic            wb_en;
   logic [PW-1:0]   wb_sel;
   logic [AW-1:0]   wb_val;
   logic [15:0]     reg_rdata;

   modport dev (
      input  mclk, rst_n, req, wr, byte_acc, space, mode, ptr_sel,
             ptr_val, step, reg_wr, reg_rd, reg_addr, reg_wdata,
      output ack, ea, wb_en, wb_sel, wb_val, reg_rdata
   );

   modport core (
      input  mclk, rst_n, ack, ea, wb_en, wb_sel, wb_val, reg_rdata,
      output req, wr, byte_acc, space, mode, ptr_sel, ptr_val, step,
             reg_wr, reg_rd, reg_addr, reg_wdata
   );

endinterface
`default_nettype wire

// file: mba_agu.sv
/*
 Device end: circular buffer and bit-reversed effective address logic.
 Holds the control, modifier and buffer bound registers.
 Assumes the core presents one access per request with the pointer value.
*/
// Local design decisions: strobed register access and the placing of the registers.
// Operation
// - X circular when select not 15, enabled
// - Y circular when select not 15, enabled
// - Bounds compared by less or greater
// - Write back only for pre/post modify
// - Offset form corrects address, keeps pointer
// - Bit-reverse only on X writes
// - Modifier added in reversed bit order
// - Bit-reverse needs select, enable, increment
// - Software aligns bit-reversed buffer start
// - Fifteen-bit pivot in modifier register
// - Word addresses, LSB clear, pivot scaled
// - Other forms or bytes give normal address
// - Next pointer is pointer plus reversed modifier
// - Bit-reverse beats X write circular
// - No read right after modifier write
// - Sixteen entries come in reversed order
// - Software sets pivot to half length
// - Separate start and end bound registers
// - Y circular addresses are word sized
`timescale 1ns/1ps
`default_nettype none
module mba_agu
   import mbagu_pkg::*;
   (
   mba_if.dev bus
   );

   // ==========================================================
   // Registers
   logic [15:0] ctl_q;
   logic [15:0] brv_q;
   logic [15:0] xstart_q;
   logic [15:0] xend_q;
   logic [15:0] ystart_q;
   logic [15:0] yend_q;

   // Reversed-carry addition: add modifier in mirrored bit order
   function automatic logic [AW-1:0] rev_add(input logic [AW-1:0] a,
                                             input logic [AW-1:0] b);
      logic [AW-1:0] ra;
      logic [AW-1:0] rb;
      logic [AW-1:0] rs;
      logic [AW-1:0] r;
      for (int i = 0; i < AW; i++) begin
         ra[i] = a[AW-1-i];
         rb[i] = b[AW-1-i];
      end
      rs = ra + rb;
      for (int i = 0; i < AW; i++) begin
         r[i] = rs[AW-1-i];
      end
      return r;
   endfunction

   // Circular wrap of a computed address into [lo, hi]
   function automatic logic [AW-1:0] wrap(input logic [AW-1:0] a,
                                          input logic [AW-1:0] lo,
                                          input logic [AW-1:0] hi,
                                          input logic          word);
      logic [AW-1:0] len;
      logic [AW-1:0] r;
      len = AW'(hi - lo + 16'h0001);
      r = a;
      if (a > hi) begin
         r = AW'(a - len);
      end else if (a < lo) begin
         r = AW'(a + len);
      end
      if (word) begin
         r[0] = 1'b0;
      end
      return r;
   endfunction

   // ==========================================================
   // Combinational address path, same cycle as the request
   logic            x_circ;
   logic            y_circ;
   logic            brev_on;
   logic            is_x;
   logic            is_pre;
   logic            is_post;
   logic            modify;
   logic [AW-1:0]   nxt_ptr;
   logic [AW-1:0]   pre_ea;
   logic [AW-1:0]   ea_d;
   logic [AW-1:0]   wbv_d;
   logic [AW-1:0]   piv_step;

   always_comb begin
      is_x    = (bus.space == MBA_SPACE_X);
      is_pre  = (bus.mode == MBA_PREINC) || (bus.mode == MBA_PREDEC);
      is_post = (bus.mode == MBA_POSTINC) || (bus.mode == MBA_POSTDEC);
      modify  = is_pre || is_post;
      // Bit-reverse conditions
      brev_on = is_x && bus.wr && !bus.byte_acc
         && (ctl_q[CTL_BSEL_LO +: PW] != PTR_NONE)
         && brv_q[BRV_EN_BIT]
         && (bus.ptr_sel == ctl_q[CTL_BSEL_LO +: PW])
         && ((bus.mode == MBA_PREINC) || (bus.mode == MBA_POSTINC));
      // Circular conditions; bit-reverse wins on X writes
      x_circ = is_x && ctl_q[CTL_XEN_BIT]
         && (ctl_q[CTL_XSEL_LO +: PW] != PTR_NONE)
         && (bus.ptr_sel == ctl_q[CTL_XSEL_LO +: PW])
         && !brev_on;
      y_circ = !is_x && ctl_q[CTL_YEN_BIT]
         && (ctl_q[CTL_YSEL_LO +: PW] != PTR_NONE)
         && (bus.ptr_sel == ctl_q[CTL_YSEL_LO +: PW]);
      // Pivot scaled to a byte step
      piv_step = {brv_q[BRV_PIV_MSB:0], 1'b0};
      // Normal next pointer from step
      if ((bus.mode == MBA_PREDEC) || (bus.mode == MBA_POSTDEC)) begin
         nxt_ptr = AW'(bus.ptr_val - bus.step);
      end else begin
         nxt_ptr = AW'(bus.ptr_val + bus.step);
      end
      pre_ea = (bus.mode == MBA_OFFSET) ? nxt_ptr : bus.ptr_val;
      ea_d  = is_pre ? nxt_ptr : pre_ea;
      wbv_d = nxt_ptr;
      if (brev_on) begin
         // Step from indirect form ignored, reversed pivot used
         wbv_d = rev_add(bus.ptr_val, piv_step);
         wbv_d[0] = 1'b0;
         ea_d = (bus.mode == MBA_PREINC) ? wbv_d : bus.ptr_val;
         ea_d[0] = 1'b0;
      end else if (x_circ) begin
         ea_d  = wrap(ea_d, xstart_q, xend_q, 1'b0);
         wbv_d = wrap(wbv_d, xstart_q, xend_q, 1'b0);
      end else if (y_circ) begin
         ea_d  = wrap(ea_d, ystart_q, yend_q, 1'b1);
         wbv_d = wrap(wbv_d, ystart_q, yend_q, 1'b1);
      end
   end

   // ==========================================================
   // Answer registers, one cycle after the request
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         bus.ack    <= 1'b0;
         bus.ea     <= '0;
         bus.wb_en  <= 1'b0;
         bus.wb_sel <= '0;
         bus.wb_val <= '0;
      end else begin
         bus.ack    <= bus.req;
         bus.ea     <= bus.req ? ea_d : bus.ea;
         bus.wb_en  <= bus.req && modify;
         bus.wb_sel <= bus.req ? bus.ptr_sel : bus.wb_sel;
         bus.wb_val <= bus.req ? wbv_d : bus.wb_val;
      end
   end

   // Software register writes
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         ctl_q    <= CTL_RESET;
         brv_q    <= BRV_RESET;
         xstart_q <= '0;
         xend_q   <= '0;
         ystart_q <= '0;
         yend_q   <= '0;
      end else if (bus.reg_wr) begin
         if (bus.reg_addr == REG_CTL) begin
            ctl_q <= bus.reg_wdata;
         end else if (bus.reg_addr == REG_BRV) begin
            brv_q <= bus.reg_wdata;
         end else if (bus.reg_addr == REG_XSTART) begin
            xstart_q <= bus.reg_wdata;
         end else if (bus.reg_addr == REG_XEND) begin
            xend_q <= bus.reg_wdata;
         end else if (bus.reg_addr == REG_YSTART) begin
            ystart_q <= bus.reg_wdata;
         end else if (bus.reg_addr == REG_YEND) begin
            yend_q <= bus.reg_wdata;
         end
      end
   end

   // Register read data, one cycle after the strobe
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         bus.reg_rdata <= '0;
      end else if (!bus.reg_rd) begin
         bus.reg_rdata <= '0;
      end else if (bus.reg_addr == REG_CTL) begin
         bus.reg_rdata <= ctl_q;
      end else if (bus.reg_addr == REG_BRV) begin
         bus.reg_rdata <= brv_q;
      end else if (bus.reg_addr == REG_XSTART) begin
         bus.reg_rdata <= xstart_q;
      end else if (bus.reg_addr == REG_XEND) begin
         bus.reg_rdata <= xend_q;
      end else if (bus.reg_addr == REG_YSTART) begin
         bus.reg_rdata <= ystart_q;
      end else if (bus.reg_addr == REG_YEND) begin
         bus.reg_rdata <= yend_q;
      end else begin
         bus.reg_rdata <= '0;
      end
   end

endmodule
`default_nettype wire

// file: mba_core.sv
/*
 Core end: forwards accesses and register orders, keeps the pointer file.
 Assumes the device answers one cycle after each request.
*/
`timescale 1ns/1ps
`default_nettype none
module mba_core
   import mbagu_pkg::*;
   (
   mba_if.core              bus,
   input  wire logic        acc_go,
   input  wire logic        acc_wr,
   input  wire logic        acc_byte,
   input  wire mba_space_t  acc_space,
   input  wire mba_mode_t   acc_mode,
   input  wire logic [3:0]  acc_ptr,
   input  wire logic [15:0] acc_step,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   input  wire logic [2:0]  sw_addr,
   input  wire logic [15:0] sw_wdata,
   input  wire logic        ptr_load,
   input  wire logic [15:0] ptr_load_val,
   output logic             acc_done,
   output logic [15:0]      acc_ea,
   output logic [15:0]      sw_rdata,
   output logic             busy
   );

   // ==========================================================
   // Pointer register file
   logic [15:0] wreg_q [16];
   logic        last_brv_wr_q;

   // Requests registered toward the device
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         bus.req       <= 1'b0;
         bus.wr        <= 1'b0;
         bus.byte_acc  <= 1'b0;
         bus.space     <= MBA_SPACE_X;
         bus.mode      <= MBA_IND;
         bus.ptr_sel   <= '0;
         bus.ptr_val   <= '0;
         bus.step      <= '0;
         bus.reg_wr    <= 1'b0;
         bus.reg_rd    <= 1'b0;
         bus.reg_addr  <= '0;
         bus.reg_wdata <= '0;
         last_brv_wr_q <= 1'b0;
      end else begin
         // Hold off an access that follows a modifier write
         bus.req      <= acc_go && !last_brv_wr_q;
         bus.wr       <= acc_wr;
         bus.byte_acc <= acc_byte;
         bus.space    <= acc_space;
         bus.mode     <= acc_mode;
         bus.ptr_sel  <= acc_ptr;
         bus.ptr_val  <= wreg_q[acc_ptr];
         bus.step     <= acc_step;
         bus.reg_wr   <= sw_wr;
         bus.reg_rd   <= sw_rd;
         bus.reg_addr <= sw_addr;
         bus.reg_wdata <= sw_wdata;
         last_brv_wr_q <= sw_wr && (sw_addr == REG_BRV);
      end
   end

   // Pointer file: load or device write back
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         for (int i = 0; i < 16; i++) begin
            wreg_q[i] <= '0;
         end
      end else if (bus.wb_en) begin
         wreg_q[bus.wb_sel] <= bus.wb_val;
      end else if (ptr_load) begin
         wreg_q[acc_ptr] <= ptr_load_val;
      end
   end

   // Results toward the user
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         acc_done <= 1'b0;
         acc_ea   <= '0;
         sw_rdata <= '0;
         busy     <= 1'b0;
      end else begin
         acc_done <= bus.ack;
         acc_ea   <= bus.ack ? bus.ea : acc_ea;
         sw_rdata <= bus.reg_rdata;
         busy     <= acc_go && last_brv_wr_q;
      end
   end

endmodule
`default_nettype wire

// file: mba_chk_sva.sv
/*
 Checker for the core-to-device interface of the address adjustment block.
 Assumes it watches the interface signals and shadows register writes.
*/
`timescale 1ns/1ps
`default_nettype none
module mba_chk
   import mbagu_pkg::*;
   (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        req,
   input wire logic        wr,
   input wire logic        byte_acc,
   input wire mba_space_t  space,
   input wire mba_mode_t   mode,
   input wire logic [3:0]  ptr_sel,
   input wire logic [15:0] ptr_val,
   input wire logic [15:0] step,
   input wire logic        reg_wr,
   input wire logic [2:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        ack,
   input wire logic [15:0] ea,
   input wire logic        wb_en,
   input wire logic [15:0] wb_val
   );
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // Shadow of control and modifier registers
   logic [15:0] ctl_q;
   logic [15:0] brv_q;
   logic        x_circ;
   logic        y_circ;
   logic        brv_on;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) ctl_q <= CTL_RESET;
      else if (reg_wr && reg_addr == REG_CTL) ctl_q <= reg_wdata;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) brv_q <= BRV_RESET;
      else if (reg_wr && reg_addr == REG_BRV) brv_q <= reg_wdata;
   end
   // Which correction applies to the current request
   assign x_circ = ctl_q[CTL_XEN_BIT]
                   && ctl_q[CTL_XSEL_LO +: PW] != PTR_NONE
                   && ptr_sel == ctl_q[CTL_XSEL_LO +: PW]
                   && space == MBA_SPACE_X;
   assign y_circ = ctl_q[CTL_YEN_BIT]
                   && ctl_q[CTL_YSEL_LO +: PW] != PTR_NONE
                   && ptr_sel == ctl_q[CTL_YSEL_LO +: PW]
                   && space == MBA_SPACE_Y;
   assign brv_on = wr && !byte_acc && space == MBA_SPACE_X
                   && brv_q[BRV_EN_BIT]
                   && ctl_q[CTL_BSEL_LO +: PW] != PTR_NONE
                   && ptr_sel == ctl_q[CTL_BSEL_LO +: PW]
                   && (mode == MBA_PREINC || mode == MBA_POSTINC);

   // ==========================================================
   // Properties
   AST_ACK_NEXT: assert property (req |=> ack)
      else $error("no answer one cycle after request");
   AST_ACK_IDLE: assert property (!req |=> !ack)
      else $error("answer without request");
   AST_WB_MODIFY: assert property (req && mode inside {MBA_POSTINC,
      MBA_POSTDEC, MBA_PREINC, MBA_PREDEC} |=> wb_en)
      else $error("modify form without write back");
   AST_WB_OFFSET: assert property (req && (mode == MBA_OFFSET
      || mode == MBA_IND) |=> !wb_en)
      else $error("write back on offset or plain form");
   AST_PRE_EA: assert property (req && (mode == MBA_PREINC
      || mode == MBA_PREDEC) |=> ea == wb_val)
      else $error("pre form address differs from new pointer");
   AST_X_PLAIN: assert property (req && space == MBA_SPACE_X && !x_circ
      && !brv_on && mode == MBA_POSTINC |=> ea == $past(ptr_val)
      && wb_val == $past(ptr_val) + $past(step))
      else $error("uncorrected X step wrong");
   AST_Y_PLAIN: assert property (req && space == MBA_SPACE_Y && !y_circ
      && mode == MBA_POSTINC |=> wb_val == $past(ptr_val)
      + $past(step))
      else $error("Y step altered");
   AST_READ_NORM: assert property (req && !wr && !x_circ
      && space == MBA_SPACE_X && mode == MBA_PREINC
      |=> ea == $past(ptr_val) + $past(step))
      else $error("X read step altered");
   AST_Y_WORD: assert property (req && y_circ |=> !ea[0])
      else $error("Y circular address odd");
   AST_BREV_WORD: assert property (req && brv_on
      |=> !ea[0] && !wb_val[0])
      else $error("bit reversed address odd");
endmodule
`default_nettype wire

// file: modulo_bitrev_agu_tb.sv
/*
 Testbench joining the core end and the device end of the adjuster.
 Assumes the core forwards each order one cycle late in each direction.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
   checks_done++; \
   if ((a) !== (e)) begin \
      n_mismatch++; \
      $display("ERROR t=%0t got %h exp %h", $time, a, e); \
   end \
end
module modulo_bitrev_agu_tb
   import mbagu_pkg::*;
   ;
   localparam logic RD = 1'b0;
   localparam logic WR = 1'b1;
   localparam logic WD = 1'b0;
   logic        mclk;
   logic        rst_n        = 1'b0;
   logic        acc_go       = 1'b0;
   logic        acc_wr       = 1'b0;
   logic        acc_byte     = 1'b0;
   mba_space_t  acc_space    = MBA_SPACE_X;
   mba_mode_t   acc_mode     = MBA_IND;
   logic [3:0]  acc_ptr      = 4'h0;
   logic [15:0] acc_step     = 16'h0000;
   logic        sw_wr        = 1'b0;
   logic        sw_rd        = 1'b0;
   logic [2:0]  sw_addr      = 3'h0;
   logic [15:0] sw_wdata     = 16'h0000;
   logic        ptr_load     = 1'b0;
   logic [15:0] ptr_load_val = 16'h0000;
   logic        acc_done;
   logic        busy;
   logic [15:0] acc_ea;
   logic [15:0] sw_rdata;
   int          n_mismatch   = 0;
   int          checks_done  = 0;

   // ==========================================================
   // Clock, ends and checker
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   mba_if mba_if_i (.mclk, .rst_n);
   mba_agu mba_agu_i (.bus(mba_if_i.dev));
   mba_core mba_core_i (.bus(mba_if_i.core), .acc_go, .acc_wr, .acc_byte,
      .acc_space, .acc_mode, .acc_ptr, .acc_step, .sw_wr, .sw_rd, .sw_addr,
      .sw_wdata, .ptr_load, .ptr_load_val, .acc_done, .acc_ea, .sw_rdata,
      .busy);
   mba_chk mba_chk_i (.mclk, .rst_n, .req(mba_if_i.req), .wr(mba_if_i.wr),
      .byte_acc(mba_if_i.byte_acc), .space(mba_if_i.space),
      .mode(mba_if_i.mode), .ptr_sel(mba_if_i.ptr_sel),
      .ptr_val(mba_if_i.ptr_val), .step(mba_if_i.step),
      .reg_wr(mba_if_i.reg_wr), .reg_addr(mba_if_i.reg_addr),
      .reg_wdata(mba_if_i.reg_wdata), .ack(mba_if_i.ack),
      .ea(mba_if_i.ea), .wb_en(mba_if_i.wb_en), .wb_val(mba_if_i.wb_val));

   // ==========================================================
   // Shared tasks
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic sw_put(input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk);
      sw_wr <= 1'b1;
      sw_addr <= a;
      sw_wdata <= d;
      @(posedge mclk);
      sw_wr <= 1'b0;
   endtask
   task automatic sw_chk(input logic [2:0] a, input logic [15:0] e);
      @(posedge mclk);
      sw_rd <= 1'b1;
      sw_addr <= a;
      @(posedge mclk);
      sw_rd <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      `CHK(sw_rdata, e)
   endtask
   task automatic ld(input logic [3:0] p, input logic [15:0] v);
      @(posedge mclk);
      ptr_load <= 1'b1;
      acc_ptr <= p;
      ptr_load_val <= v;
      @(posedge mclk);
      ptr_load <= 1'b0;
   endtask
   // One access; waits for completion and compares the address
   task automatic acc(input logic w, b, input mba_space_t s,
      input mba_mode_t m, input logic [3:0] p, input logic [15:0] st, e);
      int n;
      @(posedge mclk);
      acc_go <= 1'b1;
      acc_wr <= w;
      acc_byte <= b;
      acc_space <= s;
      acc_mode <= m;
      acc_ptr <= p;
      acc_step <= st;
      @(posedge mclk);
      acc_go <= 1'b0;
      for (n = 0; n < 8 && acc_done !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
      if (acc_done !== 1'b1) begin
         n_mismatch++;
         wrap_up();
      end
      `CHK(acc_ea, e)
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs;
      sw_chk(REG_CTL, CTL_RESET);
      sw_chk(REG_BRV, BRV_RESET);
      sw_put(REG_XSTART, 16'h0100);
      sw_put(REG_XEND, 16'h010f);
      sw_chk(REG_XEND, 16'h010f);
      sw_chk(REG_LAST, 16'h0000);
   endtask
   task automatic t_linear;
      ld(4'h1, 16'h0200);
      acc(RD, WD, MBA_SPACE_X, MBA_POSTINC, 4'h1, 16'h2, 16'h0200);
      acc(RD, WD, MBA_SPACE_X, MBA_PREDEC, 4'h1, 16'h2, 16'h0200);
      acc(RD, WD, MBA_SPACE_X, MBA_OFFSET, 4'h1, 16'h4, 16'h0204);
      acc(RD, WD, MBA_SPACE_X, MBA_IND, 4'h1, 16'h0, 16'h0200);
      acc(RD, WD, MBA_SPACE_X, MBA_POSTDEC, 4'h1, 16'h2, 16'h0200);
      acc(RD, WD, MBA_SPACE_X, MBA_IND, 4'h1, 16'h0, 16'h01fe);
   endtask
   task automatic t_xcirc;
      sw_put(REG_CTL, 16'h8ff1);
      ld(4'h1, 16'h010c);
      acc(RD, WD, MBA_SPACE_X, MBA_POSTINC, 4'h1, 16'h6, 16'h010c);
      acc(RD, WD, MBA_SPACE_X, MBA_IND, 4'h1, 16'h0, 16'h0102);
      acc(WR, WD, MBA_SPACE_X, MBA_PREDEC, 4'h1, 16'h4, 16'h010e);
      acc(RD, WD, MBA_SPACE_X, MBA_OFFSET, 4'h1, 16'h4, 16'h0102);
      acc(RD, WD, MBA_SPACE_X, MBA_IND, 4'h1, 16'h0, 16'h010e);
      ld(4'h2, 16'h010e);
      acc(RD, WD, MBA_SPACE_X, MBA_PREINC, 4'h2, 16'h4, 16'h0112);
   endtask
   task automatic t_ycirc;
      sw_put(REG_YSTART, 16'h0800);
      sw_put(REG_YEND, 16'h0807);
      sw_chk(REG_YEND, 16'h0807);
      sw_put(REG_CTL, 16'h4f3f);
      ld(4'h3, 16'h0806);
      acc(WR, WD, MBA_SPACE_Y, MBA_POSTINC, 4'h3, 16'h2, 16'h0806);
      acc(RD, WD, MBA_SPACE_Y, MBA_IND, 4'h3, 16'h0, 16'h0800);
      acc(RD, WD, MBA_SPACE_X, MBA_POSTINC, 4'h3, 16'h2, 16'h0800);
      acc(RD, WD, MBA_SPACE_X, MBA_IND, 4'h3, 16'h0, 16'h0802);
   endtask
   task automatic t_brev;
      logic [3:0] i;
      sw_put(REG_CTL, 16'h04ff);
      sw_put(REG_BRV, 16'h8008);
      ld(4'h4, 16'h0400);
      for (int k = 0; k < 16; k++) begin
         i = k[3:0];
         acc(WR, WD, MBA_SPACE_X, MBA_POSTINC, 4'h4, 16'h6,
             {11'h020, i[0], i[1], i[2], i[3], 1'b0});
      end
      ld(4'h4, 16'h0400);
      acc(WR, WD, MBA_SPACE_X, MBA_PREINC, 4'h4, 16'h2, 16'h0410);
      acc(RD, WD, MBA_SPACE_X, MBA_POSTINC, 4'h4, 16'h2, 16'h0410);
      acc(WR, 1'b1, MBA_SPACE_X, MBA_POSTINC, 4'h4, 16'h1, 16'h0412);
      acc(WR, WD, MBA_SPACE_X, MBA_PREDEC, 4'h4, 16'h2, 16'h0411);
      acc(WR, WD, MBA_SPACE_Y, MBA_POSTINC, 4'h4, 16'h2, 16'h0411);
      acc(RD, WD, MBA_SPACE_X, MBA_IND, 4'h4, 16'h0, 16'h0413);
   endtask
   task automatic t_both;
      sw_put(REG_XSTART, 16'h0400);
      sw_put(REG_XEND, 16'h040f);
      sw_put(REG_CTL, 16'h84f4);
      ld(4'h4, 16'h040e);
      acc(RD, WD, MBA_SPACE_X, MBA_PREINC, 4'h4, 16'h2, 16'h0400);
      ld(4'h4, 16'h0406);
      acc(WR, WD, MBA_SPACE_X, MBA_POSTINC, 4'h4, 16'h2, 16'h0406);
      sw_put(REG_CTL, 16'h04f4);
      acc(RD, WD, MBA_SPACE_X, MBA_IND, 4'h4, 16'h0, 16'h0416);
   endtask
   // Access right after a modifier write is held off
   task automatic t_hold;
      @(posedge mclk);
      sw_wr <= 1'b1;
      sw_addr <= REG_BRV;
      sw_wdata <= 16'h8008;
      @(posedge mclk);
      sw_wr <= 1'b0;
      acc_go <= 1'b1;
      acc_wr <= RD;
      acc_byte <= WD;
      acc_space <= MBA_SPACE_X;
      acc_mode <= MBA_POSTDEC;
      acc_ptr <= 4'h4;
      acc_step <= 16'h0002;
      @(posedge mclk);
      acc_go <= 1'b0;
      #1;
      `CHK(busy, 1'b1)
      repeat (2) @(posedge mclk);
      #1;
      `CHK(acc_done, 1'b0)
      acc(RD, WD, MBA_SPACE_X, MBA_IND, 4'h4, 16'h0, 16'h0416);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_linear();
      t_xcirc();
      t_ycirc();
      t_brev();
      t_both();
      t_hold();
      wrap_up();
   end
endmodule
`default_nettype wire
